// ---- rtl/gpk_cfg.svh ----
// register map, field widths and reset values of the eight-bit port
`ifndef GPK_CFG_SVH
`define GPK_CFG_SVH

`define GPK_PORT_WIDTH          8
`define GPK_ADDR_WIDTH          14
`define GPK_DATA_WIDTH          32

// printed register indices; the byte address is four times the index
`define GPK_IDX_OUTPUT_LATCH    12'h004
`define GPK_IDX_PIN_STATE       12'h011
`define GPK_IDX_DIRECTION       12'hf1e
`define GPK_IDX_PULLUP          12'hf2b
`define GPK_IDX_FUNC_SELECT     12'hf38
`define GPK_IDX_WAKEUP_CTRL     12'hf40

`define GPK_RST_OUTPUT_LATCH    8'h00
`define GPK_RST_DIRECTION       8'h00
`define GPK_RST_PULLUP          8'h00
`define GPK_RST_FUNC_SELECT     8'h00
`define GPK_RST_WAKEUP_CTRL     8'h00
`define GPK_RST_READDATA        32'h0000_0000

`endif

// ---- rtl/gpk_pkg.sv ----
// types shared by the eight-bit port design
package gpk_pkg;
  typedef logic [7:0]  gpk_byte_t;
  typedef logic [31:0] gpk_word_t;
  typedef logic [13:0] gpk_addr_t;

  typedef enum logic [0:0] {
    GPK_BUS_IDLE = 1'b0,
    GPK_BUS_ACK  = 1'b1
  } gpk_bus_st_t;
endpackage

// ---- rtl/gpk_sync.sv ----
// two-flop synchroniser for the pad input levels
`timescale 1ns/1ps
module gpk_sync (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire gpk_pkg::gpk_byte_t async_i,
  output gpk_pkg::gpk_byte_t     sync_o
);
  import gpk_pkg::*;

  gpk_byte_t meta_r;
  gpk_byte_t sync_r;

  // first stage is read by the second stage only
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_bit
      always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= async_i[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_r;
endmodule // gpk_sync

// ---- rtl/gpk_port.sv ----
// eight-bit port with analog routing, key wakeup and avalon-mm registers
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "gpk_cfg.svh"

module gpk_port (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_b_i,
  // avalon-mm slave
  input  wire gpk_pkg::gpk_addr_t avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire gpk_pkg::gpk_word_t avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output gpk_pkg::gpk_word_t      avs_readdata,
  output logic                    avs_waitrequest,
  // pad side
  input  wire gpk_pkg::gpk_byte_t pad_in_i,
  output gpk_pkg::gpk_byte_t      pad_out_o,
  output gpk_pkg::gpk_byte_t      pad_oe_o,
  output gpk_pkg::gpk_byte_t      pad_pullup_en_o,
  // analog converter and wakeup logic
  output gpk_pkg::gpk_byte_t      analog_channel_input_sel_o,
  output gpk_pkg::gpk_byte_t      key_wakeup_input_o
);
  import gpk_pkg::*;

  // configuration registers
  gpk_byte_t   out_latch_r;
  gpk_byte_t   out_latch_nxt;
  gpk_byte_t   dir_ctrl_r;
  gpk_byte_t   dir_ctrl_nxt;
  gpk_byte_t   pullup_ctrl_r;
  gpk_byte_t   pullup_ctrl_nxt;
  gpk_byte_t   func_sel_r;
  gpk_byte_t   func_sel_nxt;
  gpk_byte_t   wake_en_r;
  gpk_byte_t   wake_en_nxt;

  // bus slave state
  gpk_bus_st_t bus_st_r;
  gpk_bus_st_t bus_st_nxt;
  gpk_word_t   readdata_r;
  gpk_word_t   readdata_nxt;
  logic        waitreq_r;
  logic        waitreq_nxt;

  // pad-facing registered outputs
  gpk_byte_t   pad_out_r;
  gpk_byte_t   pad_out_nxt;
  gpk_byte_t   pad_oe_r;
  gpk_byte_t   pad_oe_nxt;
  gpk_byte_t   pullup_en_r;
  gpk_byte_t   pullup_en_nxt;
  gpk_byte_t   analog_sel_r;
  gpk_byte_t   analog_sel_nxt;
  gpk_byte_t   wake_in_r;
  gpk_byte_t   wake_in_nxt;

  // helpers
  gpk_byte_t   pad_sync;
  gpk_byte_t   pin_state;
  gpk_byte_t   plain_input;
  logic [11:0] reg_idx;
  logic        req;
  logic        wr_go;

  gpk_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .async_i   (pad_in_i),
    .sync_o    (pad_sync)
  );

  assign reg_idx = avs_address[13:2];
  assign req     = avs_read | avs_write;
  // a write commits only on the edge where the master sees waitrequest low
  assign wr_go   = avs_write & ~waitreq_r & avs_byteenable[0];

  // per-bit pin mode decode
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_mode
      assign plain_input[g] = ~dir_ctrl_r[g] & ~func_sel_r[g];
      // analog or output bits hide the pad level
      assign pin_state[g]   = plain_input[g] & pad_sync[g];
    end
  endgenerate

  // bus handshake: one wait cycle, then a single acknowledge cycle
  always_comb begin
    bus_st_nxt   = bus_st_r;
    waitreq_nxt  = 1'b1;
    readdata_nxt = readdata_r;
    case (bus_st_r)
      GPK_BUS_IDLE: begin
        if (req) begin
          bus_st_nxt  = GPK_BUS_ACK;
          waitreq_nxt = 1'b0;
          // read data is captured here so it stands at the ack edge
          readdata_nxt = `GPK_RST_READDATA;
          case (reg_idx)
            `GPK_IDX_OUTPUT_LATCH: readdata_nxt[7:0] = out_latch_r;
            `GPK_IDX_PIN_STATE:    readdata_nxt[7:0] = pin_state;
            `GPK_IDX_DIRECTION:    readdata_nxt[7:0] = dir_ctrl_r;
            `GPK_IDX_PULLUP:       readdata_nxt[7:0] = pullup_ctrl_r;
            `GPK_IDX_FUNC_SELECT:  readdata_nxt[7:0] = func_sel_r;
            `GPK_IDX_WAKEUP_CTRL:  readdata_nxt[7:0] = wake_en_r;
            // unmapped addresses read as zero and ignore writes
            default:               readdata_nxt = `GPK_RST_READDATA;
          endcase
        end
      end
      GPK_BUS_ACK: begin
        // one forced wait cycle keeps a held request from acking twice
        bus_st_nxt  = GPK_BUS_IDLE;
        waitreq_nxt = 1'b1;
      end
      default: begin
        bus_st_nxt  = GPK_BUS_IDLE;
        waitreq_nxt = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_st_r   <= GPK_BUS_IDLE;
      waitreq_r  <= 1'b1;
      readdata_r <= `GPK_RST_READDATA;
    end else begin
      bus_st_r   <= bus_st_nxt;
      waitreq_r  <= waitreq_nxt;
      readdata_r <= readdata_nxt;
    end
  end

  // configuration registers; only byte lane 0 carries data
  always_comb begin
    out_latch_nxt   = out_latch_r;
    dir_ctrl_nxt    = dir_ctrl_r;
    pullup_ctrl_nxt = pullup_ctrl_r;
    func_sel_nxt    = func_sel_r;
    wake_en_nxt     = wake_en_r;
    if (wr_go) begin
      case (reg_idx)
        `GPK_IDX_OUTPUT_LATCH: out_latch_nxt   = avs_writedata[7:0];
        `GPK_IDX_DIRECTION:    dir_ctrl_nxt    = avs_writedata[7:0];
        `GPK_IDX_PULLUP:       pullup_ctrl_nxt = avs_writedata[7:0];
        `GPK_IDX_FUNC_SELECT:  func_sel_nxt    = avs_writedata[7:0];
        `GPK_IDX_WAKEUP_CTRL:  wake_en_nxt     = avs_writedata[7:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_latch_r   <= `GPK_RST_OUTPUT_LATCH;
      dir_ctrl_r    <= `GPK_RST_DIRECTION;
      pullup_ctrl_r <= `GPK_RST_PULLUP;
      func_sel_r    <= `GPK_RST_FUNC_SELECT;
      wake_en_r     <= `GPK_RST_WAKEUP_CTRL;
    end else begin
      out_latch_r   <= out_latch_nxt;
      dir_ctrl_r    <= dir_ctrl_nxt;
      pullup_ctrl_r <= pullup_ctrl_nxt;
      func_sel_r    <= func_sel_nxt;
      wake_en_r     <= wake_en_nxt;
    end
  end

  // pad steering, computed per bit from the current configuration
  always_comb begin
    pad_out_nxt    = out_latch_r;
    pad_oe_nxt     = '0;
    pullup_en_nxt  = '0;
    analog_sel_nxt = '0;
    wake_in_nxt    = '0;
    for (int i = 0; i < 8; i++) begin
      if (wake_en_r[i]) begin
        // wakeup forces input: no drive, no analog, whatever else is set
        pad_oe_nxt[i]     = 1'b0;
        analog_sel_nxt[i] = 1'b0;
        wake_in_nxt[i]    = pad_sync[i];
        pullup_en_nxt[i]  = pullup_ctrl_r[i];
      end else begin
        analog_sel_nxt[i] = func_sel_r[i];
        // analog pins must not be driven digitally
        pad_oe_nxt[i]     = dir_ctrl_r[i] & ~func_sel_r[i];
        pullup_en_nxt[i]  = pullup_ctrl_r[i] & plain_input[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pad_out_r    <= '0;
      pad_oe_r     <= '0;
      pullup_en_r  <= '0;
      analog_sel_r <= '0;
      wake_in_r    <= '0;
    end else begin
      pad_out_r    <= pad_out_nxt;
      pad_oe_r     <= pad_oe_nxt;
      pullup_en_r  <= pullup_en_nxt;
      analog_sel_r <= analog_sel_nxt;
      wake_in_r    <= wake_in_nxt;
    end
  end

  assign avs_readdata               = readdata_r;
  assign avs_waitrequest            = waitreq_r;
  assign pad_out_o                  = pad_out_r;
  assign pad_oe_o                   = pad_oe_r;
  assign pad_pullup_en_o            = pullup_en_r;
  assign analog_channel_input_sel_o = analog_sel_r;
  assign key_wakeup_input_o         = wake_in_r;
endmodule // gpk_port

// ---- sim/gpk_pin_model.sv ----
// pin-side partner: resolves each pad from drive, pull-up and outside level
`timescale 1ns/1ps
module gpk_pin_model (
  input  wire gpk_pkg::gpk_byte_t out_i,
  input  wire gpk_pkg::gpk_byte_t oe_i,
  input  wire gpk_pkg::gpk_byte_t pu_i,
  input  wire gpk_pkg::gpk_byte_t ext_i,
  output gpk_pkg::gpk_byte_t      pin_o
);
  import gpk_pkg::*;
  // undriven, unpulled pins take the outside level, never a stale value
  assign pin_o = (oe_i & out_i) | (~oe_i & pu_i) | (~oe_i & ~pu_i & ext_i);
endmodule // gpk_pin_model

// ---- sim/gpk_port_checker.sv ----
// concurrent checks on the port's pins and register bus
`timescale 1ns/1ps
module gpk_port_checker (
  input wire logic               sys_clk_i,
  input wire logic               rst_b_i,
  input wire gpk_pkg::gpk_addr_t avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire gpk_pkg::gpk_word_t avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire gpk_pkg::gpk_word_t avs_readdata,
  input wire logic               avs_waitrequest,
  input wire gpk_pkg::gpk_byte_t pad_in_i,
  input wire gpk_pkg::gpk_byte_t pad_out_o,
  input wire gpk_pkg::gpk_byte_t pad_oe_o,
  input wire gpk_pkg::gpk_byte_t pad_pullup_en_o,
  input wire gpk_pkg::gpk_byte_t analog_channel_input_sel_o,
  input wire gpk_pkg::gpk_byte_t key_wakeup_input_o
);
  import gpk_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_oe_not_analog: assert property ((pad_oe_o & analog_channel_input_sel_o) == 8'h00)
    else $error("pin driven while routed to analog");
  a_wake_not_driven: assert property ((key_wakeup_input_o & pad_oe_o) == 8'h00)
    else $error("wakeup pin is driven");
  a_pullup_not_out: assert property ((pad_pullup_en_o & pad_oe_o) == 8'h00)
    else $error("pull-up on an output pin");
  a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_ack_has_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("ack without request");
  a_ack_latency: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("ack not one cycle after request");
  a_rdata_upper_zero: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_out_after_write: assert property ($changed(pad_out_o) |->
    $past(avs_write, 1) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("pad output changed without write");
  a_oe_after_write: assert property ($changed(pad_oe_o) |->
    $past(avs_write, 1) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("pad enable changed without write");
endmodule // gpk_port_checker

bind gpk_port gpk_port_checker u_chk (.sys_clk_i, .rst_b_i, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pad_in_i,
  .pad_out_o, .pad_oe_o, .pad_pullup_en_o, .analog_channel_input_sel_o, .key_wakeup_input_o);

// ---- sim/gpk_port_tb_top.sv ----
// self-checking bench: register traffic and pin behaviour of the port
`timescale 1ns/1ps
`include "gpk_cfg.svh"
module gpk_port_tb_top;
  import gpk_pkg::*;
  logic      sys_clk_i = 1'b0;
  logic      rst_b_i   = 1'b0;
  gpk_addr_t adr       = '0;
  logic      rd_q      = 1'b0;
  logic      wr_q      = 1'b0;
  gpk_word_t wdat      = '0;
  logic [3:0] be       = 4'hf;
  gpk_byte_t ext       = 8'h00;
  gpk_word_t rdat;
  logic      wait_q;
  gpk_byte_t pout, poe, ppu, ana, key_wakeup_input, pin;
  gpk_byte_t q;
  int        failures = 0;
  int        check_count = 0;
  logic [11:0] ix [5] = '{`GPK_IDX_DIRECTION, `GPK_IDX_FUNC_SELECT, `GPK_IDX_PULLUP,
                          `GPK_IDX_WAKEUP_CTRL, `GPK_IDX_OUTPUT_LATCH};
  always #2.5 sys_clk_i = ~sys_clk_i;
  gpk_port DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address(adr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_q), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe),
    .pad_pullup_en_o(ppu), .analog_channel_input_sel_o(ana), .key_wakeup_input_o(key_wakeup_input));
  gpk_pin_model u_pins (.out_i(pout), .oe_i(poe), .pu_i(ppu), .ext_i(ext), .pin_o(pin));
  task automatic close_out;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input gpk_byte_t e, input gpk_byte_t g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request holds until waitrequest is seen low at a rising edge; only the watchdog ends a hang
  task automatic bus(input logic [11:0] i, input logic wr, input gpk_byte_t v, output gpk_byte_t r);
    @(posedge sys_clk_i);
    adr <= {i, 2'b00};
    rd_q <= !wr;
    wr_q <= wr;
    wdat <= {24'h0, v};
    do begin
      @(posedge sys_clk_i);
    end while (wait_q !== 1'b0);
    r = rdat[7:0];
    rd_q <= 1'b0;
    wr_q <= 1'b0;
  endtask
  task automatic setup(input gpk_byte_t nd, nf, np, nw, nl, ne);
    gpk_byte_t r, oe, pu, lv;
    gpk_byte_t v [5];
    v = '{nd, nf, np, nw, nl};
    ext <= ne;
    foreach (ix[i]) bus(ix[i], 1'b1, v[i], r);
    repeat (6) @(posedge sys_clk_i); // pad register plus two sync flops plus wakeup flop
    oe = nd & ~nf & ~nw;
    pu = np & (nw | (~nf & ~nd));
    lv = (oe & nl) | (~oe & pu) | (~oe & ~pu & ne);
    cmp("pad_oe", oe, poe);
    cmp("pad_out", nl, pout);
    cmp("pin_drive", nl & oe, pin & oe);
    cmp("pullup", pu, ppu);
    cmp("analog", nf & ~nw, ana);
    cmp("wakeup", lv & nw, key_wakeup_input);
    bus(`GPK_IDX_PIN_STATE, 1'b0, 8'h00, r);
    cmp("pin_state", lv & ~nd & ~nf, r);
    foreach (ix[i]) begin
      bus(ix[i], 1'b0, 8'h00, r);
      cmp("readback", v[i], r);
    end
  endtask
  initial begin
    #100000;
    failures++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    foreach (ix[i]) begin
      bus(ix[i], 1'b0, 8'h00, q);
      cmp("reset", 8'h00, q);
    end
    cmp("reset_pads", 8'h00, pout | poe | ppu | ana | key_wakeup_input);
    setup(8'hff, 8'h00, 8'h00, 8'h00, 8'h3c, 8'h00);
    setup(8'h0f, 8'h30, 8'hff, 8'h00, 8'ha5, 8'h96);
    setup(8'h0f, 8'h30, 8'hff, 8'h81, 8'h5a, 8'h69);
    setup(8'h81, 8'h81, 8'h00, 8'hff, 8'hff, 8'h69);
    setup(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc3);
    bus(12'h123, 1'b1, 8'hff, q);
    bus(12'h123, 1'b0, 8'h00, q);
    cmp("unmapped", 8'h00, q);
    be <= 4'h0;
    bus(`GPK_IDX_DIRECTION, 1'b1, 8'hff, q);
    be <= 4'hf;
    bus(`GPK_IDX_DIRECTION, 1'b0, 8'h00, q);
    cmp("masked_write", 8'h00, q);
    close_out();
  end
endmodule // gpk_port_tb_top
